// [design/pscd_pkg.sv]
package pscd_pkg;

  // register map
  localparam logic [7:0]  OVR_SEL_ADDR  = 8'h5e;
  localparam logic [7:0]  OVR_SEL_RESET = 8'h00;

  // override bit positions
  localparam int unsigned OVR_DOCP_BIT  = 0;
  localparam int unsigned OVR_AOCP_BIT  = 1;
  localparam int unsigned OVR_LCF_BIT   = 2;
  localparam int unsigned OVR_VBOOT_BIT = 3;
  localparam int unsigned OVR_TON_BIT   = 4;
  localparam int unsigned OVR_MODE_BIT  = 5;
  localparam int unsigned OVR_FOVP_BIT  = 6;
  localparam int unsigned OVR_ROVP_BIT  = 7;

  // strap measurement limits
  localparam logic [3:0]  BIN_SHORT     = 4'h0;
  localparam logic [3:0]  BIN_FLOAT     = 4'hf;

  // output target after reset when no strap applies
  localparam logic [15:0] VOUT_CMD_RESET = 16'h0000;

  // conduction mode per bin, 1 = forced continuous, 0 = diode emulation
  localparam logic [15:0] MODE_FCCM_MAP = 16'hf0ff;

  // switching frequency in kHz, bin 15 first
  localparam logic [15:0][15:0] FREQ_KHZ_TAB = {
    16'h0320, 16'h04b0, 16'h0708, 16'h0190, 16'h03e8, 16'h0320, 16'h0258, 16'h0190,
    16'h07d0, 16'h0708, 16'h0578, 16'h04b0, 16'h07d0, 16'h0578, 16'h03e8, 16'h0258};

  // boot target in mV at 1:1 scale, bin 15 first
  localparam logic [15:0][15:0] VBOOT_X1_TAB = {
    16'h09c4, 16'h0708, 16'h0672, 16'h05dc, 16'h0546, 16'h04e2, 16'h04b0, 16'h044c,
    16'h041a, 16'h03e8, 16'h0384, 16'h0320, 16'h02bc, 16'h0258, 16'h01f4, 16'h0190};

  // fixed over-voltage limit in mV at 1:1 scale, bin 15 first
  localparam logic [15:0][15:0] FOVP_X1_TAB = {
    16'h0b22, 16'h0898, 16'h0898, 16'h0898, 16'h0708, 16'h0708, 16'h05dc, 16'h0546,
    16'h0546, 16'h0546, 16'h04b0, 16'h04b0, 16'h04b0, 16'h03e8, 16'h03e8, 16'h0320};

  // boot target in mV at 1:2 scale, bin 15 first
  localparam logic [15:0][15:0] VBOOT_X2_TAB = {
    16'h1388, 16'h0e10, 16'h0ce4, 16'h0bb8, 16'h0a8c, 16'h09c4, 16'h0960, 16'h0898,
    16'h0834, 16'h07d0, 16'h0708, 16'h0640, 16'h0578, 16'h04b0, 16'h03e8, 16'h0320};

  // fixed over-voltage limit in mV at 1:2 scale, bin 15 first
  localparam logic [15:0][15:0] FOVP_X2_TAB = {
    16'h1644, 16'h1130, 16'h1130, 16'h0e10, 16'h0e10, 16'h0bb8, 16'h0bb8, 16'h0a8c,
    16'h0a8c, 16'h0a8c, 16'h0960, 16'h0960, 16'h07d0, 16'h0640, 16'h0640, 16'h0640};

  // relative over/under-voltage margins in mV
  localparam logic [15:0] ROVP_150_MV = 16'h0096;
  localparam logic [15:0] ROVP_200_MV = 16'h00c8;
  localparam logic [15:0] ROVP_250_MV = 16'h00fa;
  localparam logic [15:0] ROVP_300_MV = 16'h012c;

  // first bin of each margin band
  localparam logic [3:0]  X1_BAND_200 = 4'h4;
  localparam logic [3:0]  X1_BAND_250 = 4'ha;
  localparam logic [3:0]  X1_BAND_300 = 4'hc;
  localparam logic [3:0]  X2_BAND_300 = 4'h3;

  // boot sequencer states
  typedef enum logic [1:0] {
    PSCD_ST_RESET,
    PSCD_ST_SAMPLE,
    PSCD_ST_READY
  } pscd_state_t;

endpackage : pscd_pkg

// [design/pscd_bin_decode.sv]
`timescale 1ns/100ps
`default_nettype none

module pscd_bin_decode (
  // strap bins, scale and conduction mode map
  input  wire logic [3:0]  i_mode_bin,
  input  wire logic [3:0]  i_vboot_bin,
  input  wire logic        i_scale_half,
  input  wire logic [15:0] i_mode_map,
  // decoded strap values
  output logic      [15:0] o_freq_khz,
  output logic             o_fccm,
  output logic      [15:0] o_vboot_mv,
  output logic      [15:0] o_rovp_mv,
  output logic      [15:0] o_fovp_mv
);

  wire logic [15:0] rovp_x1;
  wire logic [15:0] rovp_x2;

  // frequency and conduction mode from the mode/frequency strap
  assign o_freq_khz = pscd_pkg::FREQ_KHZ_TAB[i_mode_bin];
  assign o_fccm     = i_mode_map[i_mode_bin];

  // relative margin bands per scale
  assign rovp_x1 = (i_vboot_bin >= pscd_pkg::X1_BAND_300) ? pscd_pkg::ROVP_300_MV :
                   (i_vboot_bin >= pscd_pkg::X1_BAND_250) ? pscd_pkg::ROVP_250_MV :
                   (i_vboot_bin >= pscd_pkg::X1_BAND_200) ? pscd_pkg::ROVP_200_MV :
                   pscd_pkg::ROVP_150_MV;
  assign rovp_x2 = (i_vboot_bin >= pscd_pkg::X2_BAND_300) ? pscd_pkg::ROVP_300_MV :
                   pscd_pkg::ROVP_200_MV;

  // boot voltage and limits, selected by output scale
  assign o_vboot_mv = i_scale_half ? pscd_pkg::VBOOT_X2_TAB[i_vboot_bin]
                                   : pscd_pkg::VBOOT_X1_TAB[i_vboot_bin];
  assign o_fovp_mv  = i_scale_half ? pscd_pkg::FOVP_X2_TAB[i_vboot_bin]
                                   : pscd_pkg::FOVP_X1_TAB[i_vboot_bin];
  assign o_rovp_mv  = i_scale_half ? rovp_x2 : rovp_x1;

endmodule : pscd_bin_decode

`default_nettype wire

// [design/pscd_top.sv]
`timescale 1ns/100ps
`default_nettype none

module pscd_top #(
  parameter logic [15:0] MODE_MAP = pscd_pkg::MODE_FCCM_MAP
) (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // strap measurements and variant
  input  wire logic        i_strap_enable,
  input  wire logic [3:0]  i_mode_strap_bin,
  input  wire logic [3:0]  i_boot_voltage_strap_pin,
  input  wire logic [3:0]  i_ilim_strap_bin,
  input  wire logic [3:0]  i_addr_strap_bin,
  // output scale from the scale command
  input  wire logic        i_scale_half,
  // command register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  // bus-programmed parameter values
  input  wire logic        i_cmd_vout_wr,
  input  wire logic [15:0] i_cmd_vout_mv,
  input  wire logic [15:0] i_cmd_freq_khz,
  input  wire logic        i_cmd_fccm,
  input  wire logic [15:0] i_cmd_rovp_mv,
  input  wire logic [15:0] i_cmd_fovp_mv,
  input  wire logic [3:0]  i_cmd_docp_code,
  input  wire logic [3:0]  i_cmd_aocp_code,
  input  wire logic [3:0]  i_cmd_lcf_code,
  // effective configuration
  output logic             o_boot_done,
  output logic             o_strap_active,
  output logic      [15:0] o_vout_target_mv,
  output logic      [15:0] o_freq_khz,
  output logic             o_fccm,
  output logic             o_diode_emulation_mode,
  output logic      [15:0] o_rovp_mv,
  output logic      [15:0] o_fovp_mv,
  output logic      [3:0]  o_docp_code,
  output logic      [3:0]  o_aocp_code,
  output logic      [3:0]  o_lcf_code,
  output logic      [3:0]  o_addr_offset,
  output logic      [7:0]  o_param_from_cmd
);

  pscd_pkg::pscd_state_t state;
  pscd_pkg::pscd_state_t next_state;

  logic [7:0]  ovr_sel;
  logic [15:0] vout_cmd;
  logic        strap_en;
  logic [3:0]  mode_bin;
  logic [3:0]  vboot_bin;
  logic [3:0]  ilim_bin;
  logic [3:0]  addr_bin;

  wire logic        sample_now;
  wire logic        ovr_hit;
  wire logic [7:0]  use_cmd;
  wire logic [15:0] dec_freq_khz;
  wire logic        dec_fccm;
  wire logic [15:0] dec_vboot_mv;
  wire logic [15:0] dec_rovp_mv;
  wire logic [15:0] dec_fovp_mv;
  wire logic [15:0] next_vout;
  wire logic [15:0] next_freq;
  wire logic        next_fccm;
  wire logic        next_diode;
  wire logic [15:0] next_rovp;
  wire logic [15:0] next_fovp;
  wire logic [3:0]  next_docp;
  wire logic [3:0]  next_aocp;
  wire logic [3:0]  next_lcf;
  wire logic [7:0]  next_rdata;

  // boot sequencer: sample straps on the second edge after reset release, then hold
  always_comb begin
    case (state)
      pscd_pkg::PSCD_ST_RESET:  next_state = pscd_pkg::PSCD_ST_SAMPLE;
      pscd_pkg::PSCD_ST_SAMPLE: next_state = pscd_pkg::PSCD_ST_READY;
      pscd_pkg::PSCD_ST_READY:  next_state = pscd_pkg::PSCD_ST_READY;
      default:                  next_state = pscd_pkg::PSCD_ST_RESET;
    endcase
  end

  assign sample_now = (state == pscd_pkg::PSCD_ST_SAMPLE);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state <= pscd_pkg::PSCD_ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // strap capture, held constant until the next reset
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      strap_en  <= 1'b0;
      mode_bin  <= pscd_pkg::BIN_SHORT;
      vboot_bin <= pscd_pkg::BIN_SHORT;
      ilim_bin  <= pscd_pkg::BIN_SHORT;
      addr_bin  <= pscd_pkg::BIN_SHORT;
    end else if (sample_now) begin
      strap_en  <= i_strap_enable;
      mode_bin  <= i_mode_strap_bin;
      vboot_bin <= i_boot_voltage_strap_pin;
      ilim_bin  <= i_ilim_strap_bin;
      addr_bin  <= i_addr_strap_bin;
    end
  end

  // override select register write decode
  assign ovr_hit = (i_reg_addr == pscd_pkg::OVR_SEL_ADDR);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ovr_sel <= pscd_pkg::OVR_SEL_RESET;
    end else if (i_reg_wr && ovr_hit) begin
      ovr_sel <= i_reg_wdata;
    end
  end

  // read data: override register, unmapped addresses read zero
  assign next_rdata = ovr_hit ? ovr_sel : 8'h00;

  // output target command, zero until the host writes one
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      vout_cmd <= pscd_pkg::VOUT_CMD_RESET;
    end else if (i_cmd_vout_wr) begin
      vout_cmd <= i_cmd_vout_mv;
    end
  end

  // strap tables
  pscd_bin_decode u_decode (
    .i_mode_bin   (mode_bin),
    .i_vboot_bin  (vboot_bin),
    .i_scale_half (i_scale_half),
    .i_mode_map   (MODE_MAP),
    .o_freq_khz   (dec_freq_khz),
    .o_fccm       (dec_fccm),
    .o_vboot_mv   (dec_vboot_mv),
    .o_rovp_mv    (dec_rovp_mv),
    .o_fovp_mv    (dec_fovp_mv)
  );

  // per-parameter source: command when strapping is off or its bit is set
  assign use_cmd = ovr_sel | {8{~strap_en}};

  // source selection per parameter
  assign next_vout = use_cmd[pscd_pkg::OVR_VBOOT_BIT] ? vout_cmd : dec_vboot_mv;
  assign next_freq = use_cmd[pscd_pkg::OVR_TON_BIT]   ? i_cmd_freq_khz : dec_freq_khz;
  assign next_fccm = use_cmd[pscd_pkg::OVR_MODE_BIT]  ? i_cmd_fccm : dec_fccm;
  assign next_rovp = use_cmd[pscd_pkg::OVR_ROVP_BIT]  ? i_cmd_rovp_mv : dec_rovp_mv;
  assign next_fovp = use_cmd[pscd_pkg::OVR_FOVP_BIT]  ? i_cmd_fovp_mv : dec_fovp_mv;
  assign next_docp = use_cmd[pscd_pkg::OVR_DOCP_BIT]  ? i_cmd_docp_code : ilim_bin;
  assign next_aocp = use_cmd[pscd_pkg::OVR_AOCP_BIT]  ? i_cmd_aocp_code : ilim_bin;
  assign next_lcf  = use_cmd[pscd_pkg::OVR_LCF_BIT]   ? i_cmd_lcf_code : ilim_bin;
  assign next_diode = ~next_fccm;

  // configuration outputs, held at safe values until boot completes
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_boot_done      <= 1'b0;
      o_strap_active   <= 1'b0;
      o_vout_target_mv <= pscd_pkg::VOUT_CMD_RESET;
      o_freq_khz       <= 16'h0000;
      o_fccm           <= 1'b0;
      o_diode_emulation_mode <= 1'b0;
      o_rovp_mv        <= 16'h0000;
      o_fovp_mv        <= 16'h0000;
      o_docp_code      <= 4'h0;
      o_aocp_code      <= 4'h0;
      o_lcf_code       <= 4'h0;
      o_addr_offset    <= 4'h0;
      o_param_from_cmd <= 8'h00;
    end else if (state == pscd_pkg::PSCD_ST_READY) begin
      o_boot_done      <= 1'b1;
      o_strap_active   <= strap_en;
      o_vout_target_mv <= next_vout;
      o_freq_khz       <= next_freq;
      o_fccm           <= next_fccm;
      o_diode_emulation_mode <= next_diode;
      o_rovp_mv        <= next_rovp;
      o_fovp_mv        <= next_fovp;
      o_docp_code      <= next_docp;
      o_aocp_code      <= next_aocp;
      o_lcf_code       <= next_lcf;
      o_addr_offset    <= strap_en ? addr_bin : 4'h0;
      o_param_from_cmd <= use_cmd;
    end
  end

  // register read data
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rdata <= next_rdata;
    end
  end

endmodule : pscd_top

`default_nettype wire

// [dv/pscd_checker_assertions.sv]
`timescale 1ns/100ps
`default_nettype none

module pscd_checker (
  // clock, reset and register port
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_reg_wr,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic [7:0]  o_reg_rdata,
  // output target command
  input wire logic        i_cmd_vout_wr,
  input wire logic [15:0] i_cmd_vout_mv,
  // effective configuration
  input wire logic        o_boot_done,
  input wire logic        o_strap_active,
  input wire logic        o_fccm,
  input wire logic        o_diode_emulation_mode,
  input wire logic [7:0]  o_param_from_cmd,
  input wire logic [3:0]  o_addr_offset,
  input wire logic [15:0] o_vout_target_mv,
  input wire logic [15:0] o_freq_khz,
  input wire logic [15:0] o_rovp_mv
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // register read back and unmapped reads
  property p_rdata; i_reg_wr && i_reg_addr == 8'h5e ##1 i_reg_addr == 8'h5e |=> o_reg_rdata == $past(i_reg_wdata, 2);
  endproperty
  a_rdata: assert property (p_rdata) else $error("override readback wrong");
  property p_unmap; i_reg_addr != 8'h5e |=> o_reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");

  // disabled variant takes all eight parameters from commands, address offset zero
  property p_dis; o_boot_done && !o_strap_active |-> o_param_from_cmd == 8'hff && o_addr_offset == 4'h0;
  endproperty
  a_dis: assert property (p_dis) else $error("disabled variant uses a strap");

  // strap frequency range, never 1600
  property p_freq; o_boot_done && !o_param_from_cmd[4] |-> o_freq_khz % 200 == 0 &&
    o_freq_khz inside {[400:1400], [1800:2000]}; endproperty
  a_freq: assert property (p_freq) else $error("strap frequency out of set");
  property p_diode; o_diode_emulation_mode == (o_boot_done && !o_fccm); endproperty
  a_diode: assert property (p_diode) else $error("diode emulation flag wrong");
  property p_rovp; o_boot_done && !o_param_from_cmd[7] |-> o_rovp_mv inside {150, 200, 250, 300}; endproperty
  a_rovp: assert property (p_rovp) else $error("strap margin out of set");

  // boot state and captured variant hold until reset
  property p_hold; o_boot_done |=> o_boot_done && $stable(o_strap_active); endproperty
  a_hold: assert property (p_hold) else $error("boot state lost");

  // command target shows two edges after its write
  property p_vout; o_boot_done && o_param_from_cmd[3] && i_cmd_vout_wr ##1 !i_cmd_vout_wr
    |-> ##1 o_vout_target_mv == $past(i_cmd_vout_mv, 2); endproperty
  a_vout: assert property (p_vout) else $error("command target not applied");

  // main scenarios reached
  c_dis: cover property (o_boot_done && !o_strap_active);
  c_ovr: cover property (o_boot_done && o_param_from_cmd == 8'hff && o_strap_active);
  c_vout: cover property (i_cmd_vout_wr && o_boot_done);
endmodule : pscd_checker

bind pscd_top pscd_checker u_chk (
  .i_mclk                 (i_mclk),
  .i_rst                  (i_rst),
  .i_reg_wr               (i_reg_wr),
  .i_reg_addr             (i_reg_addr),
  .i_reg_wdata            (i_reg_wdata),
  .o_reg_rdata            (o_reg_rdata),
  .i_cmd_vout_wr          (i_cmd_vout_wr),
  .i_cmd_vout_mv          (i_cmd_vout_mv),
  .o_boot_done            (o_boot_done),
  .o_strap_active         (o_strap_active),
  .o_fccm                 (o_fccm),
  .o_diode_emulation_mode (o_diode_emulation_mode),
  .o_param_from_cmd       (o_param_from_cmd),
  .o_addr_offset          (o_addr_offset),
  .o_vout_target_mv       (o_vout_target_mv),
  .o_freq_khz             (o_freq_khz),
  .o_rovp_mv              (o_rovp_mv)
);

`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin n_errors++; \
  $display("Error %s expected %0h seen %0h", n, e, a); end end

module tb;
  logic        i_mclk, i_rst, i_strap_enable, i_scale_half, i_reg_wr, i_cmd_vout_wr, i_cmd_fccm;
  logic [3:0]  i_mode_strap_bin, i_boot_voltage_strap_pin, i_ilim_strap_bin, i_addr_strap_bin;
  logic [3:0]  i_cmd_docp_code, i_cmd_aocp_code, i_cmd_lcf_code, o_docp_code, o_aocp_code, o_lcf_code;
  logic [3:0]  o_addr_offset;
  logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, o_param_from_cmd;
  logic [15:0] i_cmd_vout_mv, i_cmd_freq_khz, i_cmd_rovp_mv, i_cmd_fovp_mv;
  logic [15:0] o_vout_target_mv, o_freq_khz, o_rovp_mv, o_fovp_mv;
  logic        o_boot_done, o_strap_active, o_fccm, o_diode_emulation_mode;
  int          n_errors, check_count;
  // expected tables in kHz and mV
  logic [15:0] ft[16] = '{600, 1000, 1400, 2000, 1200, 1400, 1800, 2000, 400, 600, 800, 1000, 400, 1800, 1200, 800};
  logic [15:0] v1[16] = '{400, 500, 600, 700, 800, 900, 1000, 1050, 1100, 1200, 1250, 1350, 1500, 1650, 1800, 2500};
  logic [15:0] f1[16] = '{800, 1000, 1000, 1200, 1200, 1200, 1350, 1350, 1350, 1500, 1800, 1800, 2200, 2200, 2200, 2850};
  logic [15:0] v2[16] = '{800, 1000, 1200, 1400, 1600, 1800, 2000, 2100, 2200, 2400, 2500, 2700, 3000, 3300, 3600, 5000};
  logic [15:0] f2[16] = '{1600, 1600, 1600, 2000, 2400, 2400, 2700, 2700, 2700, 3000, 3000, 3600, 3600, 4400, 4400, 5700};

  pscd_top DUT (
    .i_mclk                   (i_mclk),
    .i_rst                    (i_rst),
    .i_strap_enable           (i_strap_enable),
    .i_mode_strap_bin         (i_mode_strap_bin),
    .i_boot_voltage_strap_pin (i_boot_voltage_strap_pin),
    .i_ilim_strap_bin         (i_ilim_strap_bin),
    .i_addr_strap_bin         (i_addr_strap_bin),
    .i_scale_half             (i_scale_half),
    .i_reg_addr               (i_reg_addr),
    .i_reg_wr                 (i_reg_wr),
    .i_reg_wdata              (i_reg_wdata),
    .o_reg_rdata              (o_reg_rdata),
    .i_cmd_vout_wr            (i_cmd_vout_wr),
    .i_cmd_vout_mv            (i_cmd_vout_mv),
    .i_cmd_freq_khz           (i_cmd_freq_khz),
    .i_cmd_fccm               (i_cmd_fccm),
    .i_cmd_rovp_mv            (i_cmd_rovp_mv),
    .i_cmd_fovp_mv            (i_cmd_fovp_mv),
    .i_cmd_docp_code          (i_cmd_docp_code),
    .i_cmd_aocp_code          (i_cmd_aocp_code),
    .i_cmd_lcf_code           (i_cmd_lcf_code),
    .o_boot_done              (o_boot_done),
    .o_strap_active           (o_strap_active),
    .o_vout_target_mv         (o_vout_target_mv),
    .o_freq_khz               (o_freq_khz),
    .o_fccm                   (o_fccm),
    .o_diode_emulation_mode   (o_diode_emulation_mode),
    .o_rovp_mv                (o_rovp_mv),
    .o_fovp_mv                (o_fovp_mv),
    .o_docp_code              (o_docp_code),
    .o_aocp_code              (o_aocp_code),
    .o_lcf_code               (o_lcf_code),
    .o_addr_offset            (o_addr_offset),
    .o_param_from_cmd         (o_param_from_cmd)
  );

  // clock, watchdog
  initial begin
    i_mclk = 0;
    forever #50 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_errors++;
    results();
  end

  task automatic results;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // reset with given straps and wait for the boot load
  task automatic boot(input logic en, input logic [3:0] m, input logic [3:0] v);
    int k;
    i_rst = 1; i_strap_enable = en; i_mode_strap_bin = m; i_boot_voltage_strap_pin = v;
    i_ilim_strap_bin = m; i_addr_strap_bin = v; i_scale_half = 0;
    repeat (5) @(negedge i_mclk);
    `CHK("freq_in_reset", 16'h0000, o_freq_khz)
    i_rst = 0;
    for (k = 0; k < 10 && o_boot_done !== 1'b1; k++) @(negedge i_mclk);
    `CHK("boot_edges", 3, k)
    if (k == 10) results();
  endtask : boot

  task automatic wreg(input logic [7:0] d);
    i_reg_addr = pscd_pkg::OVR_SEL_ADDR; i_reg_wdata = d; i_reg_wr = 1;
    @(negedge i_mclk) i_reg_wr = 0;
    @(negedge i_mclk);
    `CHK("readback", d, o_reg_rdata)
  endtask : wreg

  task automatic vcmd(input logic [15:0] mv);
    i_cmd_vout_mv = mv; i_cmd_vout_wr = 1;
    @(negedge i_mclk) i_cmd_vout_wr = 0;
    @(negedge i_mclk);
    `CHK("vout_cmd", mv, o_vout_target_mv)
  endtask : vcmd

  // every strap bin at both scales, then held against strap changes
  task automatic t_tables;
    for (int b = 0; b < 16; b++) begin
      boot(1, b[3:0], b[3:0]);
      `CHK("freq", ft[b], o_freq_khz)
      `CHK("fccm", pscd_pkg::MODE_FCCM_MAP[b], o_fccm)
      `CHK("vboot1", v1[b], o_vout_target_mv)
      `CHK("fovp1", f1[b], o_fovp_mv)
      `CHK("rovp1", 16'(b < 4 ? 150 : b < 10 ? 200 : b < 12 ? 250 : 300), o_rovp_mv)
      `CHK("addr", b[3:0], o_addr_offset)
      `CHK("docp", b[3:0], o_docp_code)
      `CHK("aocp", b[3:0], o_aocp_code)
      `CHK("lcf", b[3:0], o_lcf_code)
      `CHK("diode", !pscd_pkg::MODE_FCCM_MAP[b], o_diode_emulation_mode)
      `CHK("strap_on", 1'b1, o_strap_active)
      i_scale_half = 1; i_mode_strap_bin = ~b[3:0]; i_boot_voltage_strap_pin = ~b[3:0];
      repeat (2) @(negedge i_mclk);
      `CHK("vboot2", v2[b], o_vout_target_mv)
      `CHK("fovp2", f2[b], o_fovp_mv)
      `CHK("rovp2", 16'(b < 3 ? 200 : 300), o_rovp_mv)
      `CHK("freq_held", ft[b], o_freq_khz)
    end
  endtask : t_tables

  // each override bit alone, all, then back to straps
  task automatic t_override;
    boot(1, 4'h1, 4'h6);
    i_reg_addr = 8'h5d;
    @(negedge i_mclk);
    `CHK("unmapped", 8'h00, o_reg_rdata)
    for (int k = 0; k < 8; k++) begin
      wreg(8'(1 << k));
      @(negedge i_mclk);
      `CHK("from_cmd", 8'(1 << k), o_param_from_cmd)
    end
    wreg(8'hff);
    @(negedge i_mclk);
    `CHK("cmd_freq", i_cmd_freq_khz, o_freq_khz)
    `CHK("cmd_fovp", i_cmd_fovp_mv, o_fovp_mv)
    `CHK("cmd_lcf", i_cmd_lcf_code, o_lcf_code)
    `CHK("cmd_docp", i_cmd_docp_code, o_docp_code)
    `CHK("cmd_aocp", i_cmd_aocp_code, o_aocp_code)
    `CHK("cmd_rovp", i_cmd_rovp_mv, o_rovp_mv)
    `CHK("cmd_fccm", i_cmd_fccm, o_fccm)
    `CHK("cmd_diode", !i_cmd_fccm, o_diode_emulation_mode)
    `CHK("cmd_vout", 16'h0000, o_vout_target_mv)
    // a target above 2.56 V is programmed at 1:2 scale
    i_scale_half = 1;
    vcmd(16'h0ce4);
    i_scale_half = 0;
    wreg(8'h00);
    @(negedge i_mclk);
    `CHK("strap_freq", 16'd1000, o_freq_khz)
    `CHK("strap_vout", 16'd1000, o_vout_target_mv)
  endtask : t_override

  // strapping disabled variant
  task automatic t_disabled;
    boot(0, 4'h2, 4'h9);
    `CHK("vout_zero", 16'h0000, o_vout_target_mv)
    `CHK("dis_freq", i_cmd_freq_khz, o_freq_khz)
    `CHK("dis_addr", 4'h0, o_addr_offset)
    `CHK("dis_src", 8'hff, o_param_from_cmd)
    `CHK("strap_off", 1'b0, o_strap_active)
    wreg(8'h5a);
    @(negedge i_mclk);
    `CHK("dis_forced", 8'hff, o_param_from_cmd)
    vcmd(16'h04b0);
  endtask : t_disabled

  initial begin
    i_rst = 1; i_strap_enable = 1; i_scale_half = 0; i_reg_wr = 0; i_reg_addr = 8'h00; i_reg_wdata = 8'h00;
    i_mode_strap_bin = 0; i_boot_voltage_strap_pin = 0; i_ilim_strap_bin = 0; i_addr_strap_bin = 0;
    i_cmd_vout_wr = 0; i_cmd_vout_mv = 0; i_cmd_freq_khz = 16'h0514; i_cmd_fccm = 0;
    i_cmd_rovp_mv = 16'h0064; i_cmd_fovp_mv = 16'h0abc; i_cmd_docp_code = 4'h5; i_cmd_aocp_code = 4'h6;
    i_cmd_lcf_code = 4'h7;
    t_tables();
    t_override();
    t_disabled();
    results();
  end
endmodule : tb

`default_nettype wire
